// >>> inc/rtcc_map.vh
// register offsets, field positions and reset values of the clock register slice
`ifndef RTCC_MAP_VH
`define RTCC_MAP_VH
`define RTCC_ADDR_W 4
`define RTCC_OFS_XFER0 4'h0
`define RTCC_OFS_XFER1 4'h1
`define RTCC_OFS_XFER2 4'h2
`define RTCC_OFS_XFER3 4'h3
`define RTCC_OFS_CTRL 4'h4
`define RTCC_OFS_SRC_SEL 4'h5
`define RTCC_OFS_CAP_CFG 4'h6
`define RTCC_OFS_PIN_CFG 4'h7
`define RTCC_OFS_MATCH0 4'h8
`define RTCC_OFS_MATCH1 4'h9
`define RTCC_OFS_MATCH2 4'ha
`define RTCC_OFS_MATCH3 4'hb
`define RTCC_OFS_IRQ_STAT 4'hc
`define RTCC_OFS_IRQ_MASK 4'hd
`define RTCC_CTRL_RUN 4
`define RTCC_CTRL_MATCH_EN 3
`define RTCC_CTRL_FLAG 2
`define RTCC_CTRL_LOAD 1
`define RTCC_CTRL_SNAP 0
`define RTCC_SRC_SEL_BIT 6
`define RTCC_CFG_STEP_EN 7
`define RTCC_CFG_AT_TARGET 6
`define RTCC_PIN_SHORT_BIT 7
`define RTCC_IRQ_MATCH 0
`define RTCC_IRQ_LOAD_DONE 1
`define RTCC_IRQ_SNAP_DONE 2
`define RTCC_IRQ_CAP_READY 3
`define RTCC_IRQ_W 4
`define RTCC_XFER_RST 8'h00
`define RTCC_PIN_RSVD_RST 7'h00
`define RTCC_STEP_INTERVAL 16'd64
`endif

// >>> design/rtcc_cap_stepper.v
// load capacitance stepper: walks the applied code toward the target
`timescale 1ns/1ps
`include "rtcc_map.vh"
module rtcc_cap_stepper #(
  parameter CODE_W = 4,
  parameter [15:0] INTERVAL = `RTCC_STEP_INTERVAL
) (
  input wire core_clk_i,
  input wire srst_i,
  input wire step_en_i,
  input wire [CODE_W-1:0] target_i,
  output reg [CODE_W-1:0] applied_o,
  output reg at_target_o
);
  reg [15:0] tick_reg;
  wire tick = (tick_reg == INTERVAL - 16'd1);

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      tick_reg <= 16'h0000;
      applied_o <= {CODE_W{1'b0}};
      at_target_o <= 1'b0;
    end else begin
      tick_reg <= tick ? 16'h0000 : tick_reg + 16'd1;
      if (!step_en_i) begin
        // stepping off: target applied at once
        applied_o <= target_i;
      end else if (tick && applied_o != target_i) begin
        if (applied_o < target_i)
          applied_o <= applied_o + {{(CODE_W-1){1'b0}}, 1'b1};
        else
          applied_o <= applied_o - {{(CODE_W-1){1'b0}}, 1'b1};
      end
      at_target_o <= (applied_o == target_i);
    end
  end
endmodule // rtcc_cap_stepper

// >>> design/rtcc_timer.v
// 32-bit timer with load and snapshot handshakes and match compare
`timescale 1ns/1ps
`include "rtcc_map.vh"
module rtcc_timer #(
  parameter W = 32
) (
  input wire core_clk_i,
  input wire srst_i,
  input wire run_i,
  input wire load_i,
  input wire [W-1:0] load_val_i,
  input wire snap_i,
  input wire [W-1:0] match_val_i,
  output reg [W-1:0] count_o,
  output reg [W-1:0] snap_val_o,
  output reg load_done_o,
  output reg snap_done_o,
  output reg match_o
);
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      count_o <= {W{1'b0}};
      snap_val_o <= {W{1'b0}};
      load_done_o <= 1'b0;
      snap_done_o <= 1'b0;
      match_o <= 1'b0;
    end else begin
      load_done_o <= load_i;
      snap_done_o <= snap_i;
      if (load_i)
        count_o <= load_val_i;
      else if (run_i)
        count_o <= count_o + {{(W-1){1'b0}}, 1'b1};
      if (snap_i)
        snap_val_o <= count_o;
      match_o <= (count_o == match_val_i);
    end
  end
endmodule // rtcc_timer

// >>> design/rtcc_core.v
// clock register slice: transfer, match, capacitance and pin configuration registers
// Overview of operation
// - bit 7 of cap config enables stepping
// - bit 6 reads one once load matches target
// - bits 3:0 hold programmed target load code
// - cap config bits 5:4 read zero
// - pin config bit 7 shorts oscillator pins while source select is 0 (self-oscillate)
// - four transfer bytes form 32-bit value
// - transfers occur only on load/snapshot request
// - transfer byte 0 is least significant
// - match bytes at 0x08-0x0b, low first
// - load request self-clears when load done
// - snapshot request self-clears when copy done
// - source select 0 self-oscillate, 1 crystal
`timescale 1ns/1ps
`include "rtcc_map.vh"
module rtcc_core #(
  parameter CAP_RST = 4'h0,
  parameter PIN_RSVD_RST = `RTCC_PIN_RSVD_RST
) (
  input wire core_clk_i,
  input wire srst_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  output reg irq_o,
  output reg osc_pin_short_o,
  output reg osc_source_sel_o,
  output reg [3:0] cap_applied_o,
  output reg match_event_flag_o
);
  reg [31:0] xfer_reg;
  reg [31:0] match_reg;
  reg run_reg;
  reg match_event_en_reg;
  reg match_event_flag_reg;
  reg timer_load_req_reg;
  reg timer_snapshot_req_reg;
  reg load_go_reg;
  reg snap_go_reg;
  reg osc_source_sel_reg;
  reg auto_cap_step_en_reg;
  reg [3:0] load_cap_target_reg;
  reg osc_pin_short_reg;
  reg [6:0] pin_rsvd_reg;
  reg [3:0] irq_stat_reg;
  reg [3:0] irq_mask_reg;
  reg cap_ready_d_reg;
  reg [7:0] rdata_next;
  reg [3:0] irq_stat_next;
  wire [31:0] count;
  wire [31:0] snap_val;
  wire load_done;
  wire snap_done;
  wire match_hit;
  wire [3:0] cap_applied;
  wire cap_at_target;
  wire [3:0] ev;

  wire wr_ctrl = wr_i && addr_i == `RTCC_OFS_CTRL;
  wire wr_stat = wr_i && addr_i == `RTCC_OFS_IRQ_STAT;
  wire match_set = match_event_en_reg && match_hit;
  wire [7:0] ctrl_rd = {3'b000, run_reg, match_event_en_reg, match_event_flag_reg,
    timer_load_req_reg, timer_snapshot_req_reg};

  rtcc_timer #(
    .W(32)
  ) u_timer (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .run_i(run_reg),
    .load_i(load_go_reg),
    .load_val_i(xfer_reg),
    .snap_i(snap_go_reg),
    .match_val_i(match_reg),
    .count_o(count),
    .snap_val_o(snap_val),
    .load_done_o(load_done),
    .snap_done_o(snap_done),
    .match_o(match_hit)
  );

  rtcc_cap_stepper #(
    .CODE_W(4)
  ) u_stepper (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .step_en_i(auto_cap_step_en_reg),
    .target_i(load_cap_target_reg),
    .applied_o(cap_applied),
    .at_target_o(cap_at_target)
  );

  // per-byte transfer and match writes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_byte
      always @(posedge core_clk_i) begin
        if (srst_i) begin
          xfer_reg[gi*8 +: 8] <= `RTCC_XFER_RST;
          match_reg[gi*8 +: 8] <= 8'h00;
        end else begin
          if (snap_done && timer_snapshot_req_reg)
            xfer_reg[gi*8 +: 8] <= snap_val[gi*8 +: 8];
          else if (wr_i && addr_i == gi)
            xfer_reg[gi*8 +: 8] <= wdata_i;
          if (wr_i && addr_i == `RTCC_OFS_MATCH0 + gi)
            match_reg[gi*8 +: 8] <= wdata_i;
        end
      end
    end
  endgenerate

  assign ev = {cap_at_target && !cap_ready_d_reg, snap_done, load_done, match_set};

  always @* begin
    irq_stat_next = irq_stat_reg;
    if (wr_stat)
      irq_stat_next = irq_stat_reg & ~wdata_i[3:0];
    irq_stat_next = irq_stat_next | ev;
  end

  always @* begin
    case (addr_i)
      `RTCC_OFS_XFER0: rdata_next = xfer_reg[7:0];
      `RTCC_OFS_XFER1: rdata_next = xfer_reg[15:8];
      `RTCC_OFS_XFER2: rdata_next = xfer_reg[23:16];
      `RTCC_OFS_XFER3: rdata_next = xfer_reg[31:24];
      `RTCC_OFS_CTRL: rdata_next = ctrl_rd;
      `RTCC_OFS_SRC_SEL: rdata_next = {1'b0, osc_source_sel_reg, 6'h00};
      `RTCC_OFS_CAP_CFG: rdata_next = {auto_cap_step_en_reg, cap_at_target,
        2'b00, load_cap_target_reg};
      `RTCC_OFS_PIN_CFG: rdata_next = {osc_pin_short_reg, pin_rsvd_reg};
      `RTCC_OFS_MATCH0: rdata_next = match_reg[7:0];
      `RTCC_OFS_MATCH1: rdata_next = match_reg[15:8];
      `RTCC_OFS_MATCH2: rdata_next = match_reg[23:16];
      `RTCC_OFS_MATCH3: rdata_next = match_reg[31:24];
      `RTCC_OFS_IRQ_STAT: rdata_next = {4'h0, irq_stat_reg};
      `RTCC_OFS_IRQ_MASK: rdata_next = {4'h0, irq_mask_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
      irq_o <= 1'b0;
      osc_pin_short_o <= 1'b0;
      osc_source_sel_o <= 1'b0;
      cap_applied_o <= 4'h0;
      match_event_flag_o <= 1'b0;
      run_reg <= 1'b0;
      match_event_en_reg <= 1'b0;
      match_event_flag_reg <= 1'b0;
      timer_load_req_reg <= 1'b0;
      timer_snapshot_req_reg <= 1'b0;
      load_go_reg <= 1'b0;
      snap_go_reg <= 1'b0;
      osc_source_sel_reg <= 1'b0;
      auto_cap_step_en_reg <= 1'b0;
      load_cap_target_reg <= CAP_RST;
      osc_pin_short_reg <= 1'b0;
      pin_rsvd_reg <= PIN_RSVD_RST;
      irq_stat_reg <= 4'h0;
      irq_mask_reg <= 4'h0;
      cap_ready_d_reg <= 1'b0;
    end else begin
      rdata_o <= rd_i ? rdata_next : 8'h00;
      load_go_reg <= 1'b0;
      snap_go_reg <= 1'b0;
      cap_ready_d_reg <= cap_at_target;
      if (wr_ctrl) begin
        run_reg <= wdata_i[`RTCC_CTRL_RUN];
        match_event_en_reg <= wdata_i[`RTCC_CTRL_MATCH_EN];
        if (wdata_i[`RTCC_CTRL_LOAD] && !timer_load_req_reg) begin
          timer_load_req_reg <= 1'b1;
          load_go_reg <= 1'b1;
        end
        if (wdata_i[`RTCC_CTRL_SNAP] && !timer_snapshot_req_reg) begin
          timer_snapshot_req_reg <= 1'b1;
          snap_go_reg <= 1'b1;
        end
      end
      if (load_done)
        timer_load_req_reg <= 1'b0;
      if (snap_done)
        timer_snapshot_req_reg <= 1'b0;
      // control write clears the flag, a same-cycle match still sets it
      if (match_set)
        match_event_flag_reg <= 1'b1;
      else if (wr_ctrl)
        match_event_flag_reg <= 1'b0;
      if (wr_i && addr_i == `RTCC_OFS_SRC_SEL)
        osc_source_sel_reg <= wdata_i[`RTCC_SRC_SEL_BIT];
      if (wr_i && addr_i == `RTCC_OFS_CAP_CFG) begin
        auto_cap_step_en_reg <= wdata_i[`RTCC_CFG_STEP_EN];
        load_cap_target_reg <= wdata_i[3:0];
      end
      if (wr_i && addr_i == `RTCC_OFS_PIN_CFG) begin
        osc_pin_short_reg <= wdata_i[`RTCC_PIN_SHORT_BIT];
        pin_rsvd_reg <= wdata_i[6:0];
      end
      if (wr_i && addr_i == `RTCC_OFS_IRQ_MASK)
        irq_mask_reg <= wdata_i[3:0];
      irq_stat_reg <= irq_stat_next;
      irq_o <= |(irq_stat_next & irq_mask_reg);
      // pin short only applies in self-oscillate mode
      osc_pin_short_o <= osc_pin_short_reg && !osc_source_sel_reg;
      osc_source_sel_o <= osc_source_sel_reg;
      cap_applied_o <= cap_applied;
      match_event_flag_o <= match_event_flag_reg;
    end
  end
endmodule // rtcc_core

// >>> dv/rtcc_core_asserts.sv
// port-level assertions for the clock register slice
`timescale 1ns/1ps
module rtcc_core_asserts (
  input wire core_clk_i,
  input wire srst_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire irq_o,
  input wire osc_pin_short_o,
  input wire osc_source_sel_o,
  input wire [3:0] cap_applied_o,
  input wire match_event_flag_o
);
  reg step_reg;
  reg en_reg;
  reg src_reg;
  wire cfg_wr = wr_i && addr_i == 4'h6;
  wire ctl_wr = wr_i && addr_i == 4'h4;
  // shadows of stepping enable, match enable and source select, taken from bus writes
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      step_reg <= 1'b0;
      en_reg <= 1'b0;
      src_reg <= 1'b0;
    end else begin
      if (cfg_wr) step_reg <= wdata_i[7];
      if (ctl_wr) en_reg <= wdata_i[3];
      if (wr_i && addr_i == 4'h5) src_reg <= wdata_i[6];
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read answer");
  AST_CFG_UNUSED: assert property ((rd_i && addr_i == 4'h6) |=> rdata_o[5:4] == 2'b00)
    else $error("unused config bits read nonzero");
  AST_UNMAPPED: assert property ((rd_i && addr_i >= 4'he) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_SRC_CRYSTAL: assert property ((wr_i && addr_i == 4'h5 && wdata_i[6]) |->
    ##2 (osc_source_sel_o && !osc_pin_short_o))
    else $error("crystal mode did not remove the pin short");
  AST_PIN_SHORT: assert property ((wr_i && addr_i == 4'h7 && wdata_i[7] && !src_reg) |->
    ##2 osc_pin_short_o)
    else $error("pin short not applied");
  AST_CAP_FOLLOW: assert property ((cfg_wr && !wdata_i[7]) |->
    ##3 cap_applied_o == $past(wdata_i[3:0], 3))
    else $error("applied code did not follow target");
  AST_ONE_STEP: assert property ((step_reg && $past(step_reg) && cap_applied_o != $past(cap_applied_o))
    |-> (cap_applied_o - $past(cap_applied_o) == 4'h1 || $past(cap_applied_o) - cap_applied_o == 4'h1))
    else $error("applied code moved by more than one step");
  AST_FLAG_CAUSE: assert property ($rose(match_event_flag_o) |-> $past(en_reg))
    else $error("match flag set while matching disabled");
  AST_FLAG_CLR: assert property (ctl_wr |-> ##2 !match_event_flag_o)
    else $error("control write did not clear match flag");
  AST_IRQ_MASKED: assert property ((wr_i && addr_i == 4'hd && wdata_i == 8'h00) |-> ##2 !irq_o)
    else $error("interrupt high with all sources masked");
endmodule // rtcc_core_asserts

// >>> dv/tb_top.sv
// self-checking bench for the clock register slice
`timescale 1ns/1ps
module tb_top;
  reg core_clk_i = 1'b0;
  reg srst_i = 1'b1;
  reg [3:0] addr_i = 4'h0;
  reg [7:0] wdata_i = 8'h00;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  wire [7:0] rdata_o;
  wire irq_o;
  wire osc_pin_short_o;
  wire osc_source_sel_o;
  wire [3:0] cap_applied_o;
  wire match_event_flag_o;
  reg rd_d = 1'b0;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int checks = 0;
  reg [31:0] v;
  reg [3:0] t;
  integer i;
  always #2.5 core_clk_i = ~core_clk_i;
  rtcc_core uut (.core_clk_i(core_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .osc_pin_short_o(osc_pin_short_o),
    .osc_source_sel_o(osc_source_sel_o), .cap_applied_o(cap_applied_o),
    .match_event_flag_o(match_event_flag_o));
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic guard(input bit ok);
    if (!ok) begin
      n_fail++;
      $display("timeout at %0t", $time);
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr_i <= a;
    rd_i <= 1'b1;
    wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic nop(input int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge core_clk_i);
  endtask
  // read answers are compared one cycle after the strobe was taken
  always @(posedge core_clk_i) begin
    if (rd_d) chk(exp_q.pop_front(), rdata_o);
    rd_d <= rd_i;
  end
  initial begin
    v = $urandom(89);
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    wr(4'hd, 8'h00);
    wr(4'he, 8'hff);
    // the applied code reaches its target just after reset, which latches status bit 3
    for (i = 0; i < 16; i++) if (i != 7) rd(i[3:0], (i == 6) ? 8'h40 : (i == 12) ? 8'h08 : 8'h00);
    nop(2);
    $display("test reset values done");
    wr(4'h6, 8'h3a);
    nop(4);
    chk({4'h0, cap_applied_o}, 8'h0a);
    rd(4'h6, 8'h4a);
    // a target of 7 or less lies at least three steps from 0xa, so bit 6 still reads 0 below
    t = 4'($urandom) & 4'h7;
    wr(4'h6, {4'h8, t});
    nop(2);
    rd(4'h6, {4'h8, t});
    nop(1);
    for (i = 0; i < 1100 && cap_applied_o !== t; i++) @(posedge core_clk_i);
    guard(i < 1100);
    nop(3);
    rd(4'h6, {4'hc, t});
    wr(4'h6, 8'h05);
    nop(3);
    $display("test capacitance done");
    wr(4'h5, 8'h00);
    rd(4'h7, 8'h00);
    wr(4'h7, 8'h80);
    nop(3);
    chk({7'h0, osc_pin_short_o}, 8'h01);
    wr(4'h5, 8'h40);
    nop(3);
    chk({6'h0, osc_source_sel_o, osc_pin_short_o}, 8'h02);
    wr(4'h5, 8'h00);
    rd(4'h7, 8'h80);
    wr(4'h7, 8'h00);
    nop(3);
    chk({7'h0, osc_pin_short_o}, 8'h00);
    $display("test pin config done");
    v = $urandom;
    for (i = 0; i < 4; i++) wr(i[3:0], v[8*i +: 8]);
    wr(4'h4, 8'h02);
    nop(4);
    rd(4'h4, 8'h00);
    for (i = 0; i < 4; i++) wr(i[3:0], ~v[8*i +: 8]);
    for (i = 0; i < 4; i++) rd(i[3:0], ~v[8*i +: 8]);
    nop(1);
    chk({7'h0, irq_o}, 8'h00);
    wr(4'h4, 8'h01);
    nop(4);
    rd(4'h4, 8'h00);
    for (i = 0; i < 4; i++) rd(i[3:0], v[8*i +: 8]);
    rd(4'hc, 8'h0e);
    nop(2);
    $display("test transfer done");
    wr(4'hd, 8'h01);
    v = v + 32'd20;
    // matching is still disabled while the match bytes change
    for (i = 0; i < 4; i++) wr(i[3:0] + 4'h8, v[8*i +: 8]);
    for (i = 0; i < 4; i++) rd(i[3:0] + 4'h8, v[8*i +: 8]);
    wr(4'h4, 8'h18);
    nop(1);
    for (i = 0; i < 60 && match_event_flag_o !== 1'b1; i++) @(posedge core_clk_i);
    guard(i < 60);
    nop(2);
    chk({7'h0, irq_o}, 8'h01);
    rd(4'h4, 8'h1c);
    wr(4'hc, 8'h0f);
    nop(3);
    chk({7'h0, irq_o}, 8'h00);
    wr(4'h4, 8'h10);
    nop(3);
    chk({7'h0, match_event_flag_o}, 8'h00);
    wr(4'hd, 8'h00);
    nop(3);
    $display("test match and interrupt done");
    report_and_stop();
  end
endmodule // tb_top
bind rtcc_core rtcc_core_asserts u_chk (.core_clk_i(core_clk_i), .srst_i(srst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .osc_pin_short_o(osc_pin_short_o), .osc_source_sel_o(osc_source_sel_o),
  .cap_applied_o(cap_applied_o), .match_event_flag_o(match_event_flag_o));
